//--- stf_pkg.sv
package stf_pkg;
// Contract
// - Bit rate only 1200 to 115200 steps
// - Five to eight data bits per character
// - Parity none, even or odd, both directions
// - One or two stop bits
// - Hardware flow pauses sending while partner full
// - No flow control ignores handshake lines
// - RTS when data waits, send only with CTS
// - Network bytes go out serially in order
// - Byte count reaching trigger length closes frame
// - Framing timeout sends the partial buffer
// - Whichever trigger comes first closes frame
// - Server drops link after idle timeout
// - Client retries connection each retry interval
// - New settings apply about ten seconds later
// - TCP or UDP; link timers only TCP
// - Defaults: 64 bytes and 80 ms

    localparam int CLK_HZ = 100_000_000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS = 1_000_000;
    localparam int SEC_NS = 1_000_000_000;
    localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
    localparam int CYC_PER_SEC = SEC_NS / CLK_PERIOD_NS;
    localparam logic [3:0] APPLY_DELAY_S = 4'hA;

    localparam logic [7:0] ADDR_CFG = 8'h00;
    localparam logic [7:0] ADDR_TRIG_LEN = 8'h04;
    localparam logic [7:0] ADDR_TRIG_TMO = 8'h08;
    localparam logic [7:0] ADDR_LINK_TMO = 8'h0C;
    localparam logic [7:0] ADDR_RETRY = 8'h10;
    localparam logic [7:0] ADDR_CMD = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_ACTIVE = 8'h1C;

    localparam int CMD_RESTORE = 0;
    localparam int ST_PERR = 0;
    localparam int ST_FERR = 1;
    localparam int ST_OVR = 2;
    localparam int ST_PEND = 3;
    localparam int ST_CONN = 4;
    localparam int ST_TXBUSY = 5;

    typedef enum logic [1:0] {PAR_NONE = 2'b00, PAR_EVEN = 2'b01, PAR_ODD = 2'b10} stf_par_t;

    typedef struct packed {
        logic server;
        logic udp;
        logic flowHw;
        logic stop2;
        stf_par_t parity;
        logic [1:0] dataBits;
        logic [2:0] baudSel;
    } stf_cfg_t;

    localparam int CFG_W = 11;
    localparam stf_cfg_t CFG_RST = '{server: 1'b0, udp: 1'b0, flowHw: 1'b0, stop2: 1'b0,
        parity: PAR_NONE, dataBits: 2'h3, baudSel: 3'h7};

    localparam logic [10:0] LEN_RST = 11'h040;
    localparam logic [10:0] LEN_MIN = 11'h020;
    localparam logic [10:0] LEN_MAX = 11'h400;
    localparam logic [13:0] TMO_RST = 14'h0050;
    localparam logic [13:0] TMO_MIN = 14'h0032;
    localparam logic [13:0] TMO_MAX = 14'h2710;
    localparam logic [15:0] LINK_RST = 16'h0078;
    localparam logic [15:0] RETRY_RST = 16'h000A;

    typedef enum logic [2:0] {U_IDLE = 3'b000, U_START = 3'b001, U_DATA = 3'b010,
        U_PAR = 3'b011, U_STOP = 3'b100} stf_ust_t;

    function automatic logic [16:0] baud_div(input logic [2:0] sel);
        case (sel)
            3'h0: baud_div = 17'(CLK_HZ / 1200);
            3'h1: baud_div = 17'(CLK_HZ / 2400);
            3'h2: baud_div = 17'(CLK_HZ / 4800);
            3'h3: baud_div = 17'(CLK_HZ / 9600);
            3'h4: baud_div = 17'(CLK_HZ / 19200);
            3'h5: baud_div = 17'(CLK_HZ / 38400);
            3'h6: baud_div = 17'(CLK_HZ / 57600);
            default: baud_div = 17'(CLK_HZ / 115200);
        endcase
    endfunction
endpackage

//--- stf_buf2.sv
`timescale 1ns/1ps
module stf_buf2 #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : gChk
        $error("stf_buf2: DEPTH must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wrPtr_ff;
    logic [AW-1:0] rdPtr_ff;
    logic [AW:0] count_ff;
    logic [AW:0] nxt_count;
    logic push;
    logic pop;

    assign push = inValid && inReady;
    assign pop = outValid && outReady;
    assign outData = mem_ff[rdPtr_ff];

    always_comb begin
        nxt_count = count_ff;
        if (push && !pop) begin
            nxt_count = count_ff + (AW+1)'(1);
        end else if (pop && !push) begin
            nxt_count = count_ff - (AW+1)'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wrPtr_ff] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
            inReady <= 1'b0;
            outValid <= 1'b0;
        end else begin
            if (push) begin
                wrPtr_ff <= wrPtr_ff + AW'(1);
            end
            if (pop) begin
                rdPtr_ff <= rdPtr_ff + AW'(1);
            end
            count_ff <= nxt_count;
            inReady <= nxt_count != (AW+1)'(DEPTH);
            outValid <= nxt_count != '0;
        end
    end
endmodule // stf_buf2

//--- stf_packetizer.sv
`timescale 1ns/1ps
module stf_packetizer #(
    parameter int CYC_PER_MS = stf_pkg::CYC_PER_MS,
    parameter int CYC_PER_SEC = stf_pkg::CYC_PER_SEC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic rxd,
    output logic txd,
    input wire logic cts,
    output logic rts,
    input wire logic netRxValid,
    input wire logic [7:0] netRxData,
    output logic netRxReady,
    output logic netTxValid,
    output logic [7:0] netTxData,
    input wire logic netTxReady,
    output logic frameEnd,
    output logic [10:0] frameLen,
    input wire logic netPktRx,
    input wire logic netConnected,
    output logic linkDrop,
    output logic reconnectReq
);
    if (CYC_PER_MS < 1 || CYC_PER_SEC < CYC_PER_MS) begin : gChk
        $error("stf_packetizer: tick counts out of range");
    end

    // Bus slave
    logic apValid;
    logic wrPend_ff;
    logic [7:0] wrAddr_ff;
    logic wrEn;
    logic [31:0] rdMux;
    stf_pkg::stf_cfg_t pndCfg_ff;
    stf_pkg::stf_cfg_t actCfg_ff;
    logic [10:0] pndLen_ff;
    logic [10:0] actLen_ff;
    logic [13:0] pndTmo_ff;
    logic [13:0] actTmo_ff;
    logic [15:0] pndLink_ff;
    logic [15:0] actLink_ff;
    logic [15:0] pndRetry_ff;
    logic [15:0] actRetry_ff;
    logic applyPend_ff;
    logic [3:0] applySec_ff;
    logic [2:0] sticky_ff;
    logic [2:0] stickySet;
    logic txBusy;
    stf_pkg::stf_ust_t txSt_ff;

    assign apValid = hsel && htrans[1] && hready;
    assign wrEn = wrPend_ff;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wrPend_ff <= 1'b0;
            wrAddr_ff <= 8'h00;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
        end else begin
            wrPend_ff <= apValid && hwrite;
            if (apValid) begin
                wrAddr_ff <= haddr[7:0];
            end
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (apValid && !hwrite) begin
                hrdata <= rdMux;
            end
        end
    end

    always_comb begin
        rdMux = 32'h0000_0000;
        case (haddr[7:0])
            stf_pkg::ADDR_CFG: rdMux = {21'h0, pndCfg_ff};
            stf_pkg::ADDR_TRIG_LEN: rdMux = {21'h0, pndLen_ff};
            stf_pkg::ADDR_TRIG_TMO: rdMux = {18'h0, pndTmo_ff};
            stf_pkg::ADDR_LINK_TMO: rdMux = {16'h0, pndLink_ff};
            stf_pkg::ADDR_RETRY: rdMux = {16'h0, pndRetry_ff};
            stf_pkg::ADDR_STATUS: rdMux = {26'h0, txBusy, netConnected, applyPend_ff, sticky_ff};
            stf_pkg::ADDR_ACTIVE: rdMux = {21'h0, actCfg_ff};
            default: rdMux = 32'h0000_0000;
        endcase
    end

    // Prescalers for millisecond and second ticks
    logic [31:0] msCnt_ff;
    logic [31:0] secCnt_ff;
    logic msTick_ff;
    logic secTick_ff;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            msCnt_ff <= 32'h0000_0000;
            secCnt_ff <= 32'h0000_0000;
            msTick_ff <= 1'b0;
            secTick_ff <= 1'b0;
        end else begin
            msTick_ff <= msCnt_ff == 32'(CYC_PER_MS - 1);
            secTick_ff <= secCnt_ff == 32'(CYC_PER_SEC - 1);
            msCnt_ff <= (msCnt_ff == 32'(CYC_PER_MS - 1)) ? 32'h0000_0000 : msCnt_ff + 32'h1;
            secCnt_ff <= (secCnt_ff == 32'(CYC_PER_SEC - 1)) ? 32'h0000_0000 : secCnt_ff + 32'h1;
        end
    end

    // Pending and active settings
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pndCfg_ff <= stf_pkg::CFG_RST;
            actCfg_ff <= stf_pkg::CFG_RST;
            pndLen_ff <= stf_pkg::LEN_RST;
            actLen_ff <= stf_pkg::LEN_RST;
            pndTmo_ff <= stf_pkg::TMO_RST;
            actTmo_ff <= stf_pkg::TMO_RST;
            pndLink_ff <= stf_pkg::LINK_RST;
            actLink_ff <= stf_pkg::LINK_RST;
            pndRetry_ff <= stf_pkg::RETRY_RST;
            actRetry_ff <= stf_pkg::RETRY_RST;
            applyPend_ff <= 1'b0;
            applySec_ff <= 4'h0;
        end else if (wrEn && wrAddr_ff != stf_pkg::ADDR_STATUS && wrAddr_ff != stf_pkg::ADDR_ACTIVE
                     && wrAddr_ff[7:5] == 3'h0 && wrAddr_ff[1:0] == 2'h0) begin
            applyPend_ff <= 1'b1;
            applySec_ff <= 4'h0;
            case (wrAddr_ff)
                stf_pkg::ADDR_CFG: pndCfg_ff <= stf_pkg::stf_cfg_t'(hwdata[10:0]);
                stf_pkg::ADDR_TRIG_LEN: begin
                    pndLen_ff <= (hwdata > 32'(stf_pkg::LEN_MAX)) ? stf_pkg::LEN_MAX :
                                 (hwdata < 32'(stf_pkg::LEN_MIN)) ? stf_pkg::LEN_MIN : hwdata[10:0];
                end
                stf_pkg::ADDR_TRIG_TMO: begin
                    pndTmo_ff <= (hwdata > 32'(stf_pkg::TMO_MAX)) ? stf_pkg::TMO_MAX :
                                 (hwdata < 32'(stf_pkg::TMO_MIN)) ? stf_pkg::TMO_MIN : hwdata[13:0];
                end
                stf_pkg::ADDR_LINK_TMO: pndLink_ff <= hwdata[15:0];
                stf_pkg::ADDR_RETRY: pndRetry_ff <= hwdata[15:0];
                stf_pkg::ADDR_CMD: begin
                    if (hwdata[stf_pkg::CMD_RESTORE]) begin
                        pndCfg_ff <= stf_pkg::CFG_RST;
                        pndLen_ff <= stf_pkg::LEN_RST;
                        pndTmo_ff <= stf_pkg::TMO_RST;
                        pndLink_ff <= stf_pkg::LINK_RST;
                        pndRetry_ff <= stf_pkg::RETRY_RST;
                    end
                end
                default: pndCfg_ff <= pndCfg_ff;
            endcase
        end else if (applyPend_ff && secTick_ff) begin
            if (applySec_ff == stf_pkg::APPLY_DELAY_S - 4'h1) begin
                actCfg_ff <= pndCfg_ff;
                actLen_ff <= pndLen_ff;
                actTmo_ff <= pndTmo_ff;
                actLink_ff <= pndLink_ff;
                actRetry_ff <= pndRetry_ff;
                applyPend_ff <= 1'b0;
            end else begin
                applySec_ff <= applySec_ff + 4'h1;
            end
        end
    end

    // Sticky error flags; a new event wins over a clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sticky_ff <= 3'h0;
        end else if (wrEn && wrAddr_ff == stf_pkg::ADDR_STATUS) begin
            sticky_ff <= (sticky_ff & ~hwdata[2:0]) | stickySet;
        end else begin
            sticky_ff <= sticky_ff | stickySet;
        end
    end

    // Network to serial path
    logic bufValid;
    logic [7:0] bufData;
    logic txPop;
    logic [16:0] div;
    logic [2:0] lastIdx;

    assign div = stf_pkg::baud_div(actCfg_ff.baudSel);
    assign lastIdx = 3'(actCfg_ff.dataBits) + 3'h4;
    assign txBusy = txSt_ff != stf_pkg::U_IDLE;
    assign txPop = bufValid && !txBusy && (!actCfg_ff.flowHw || cts);

    stf_buf2 #(.WIDTH(8), .DEPTH(2)) uBuf (
        .clk(clk),
        .sys_rst(sys_rst),
        .inValid(netRxValid),
        .inReady(netRxReady),
        .inData(netRxData),
        .outValid(bufValid),
        .outReady(txPop),
        .outData(bufData)
    );

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rts <= 1'b0;
        end else begin
            rts <= actCfg_ff.flowHw && (bufValid || txBusy);
        end
    end

    logic [16:0] txCnt_ff;
    logic [2:0] txBit_ff;
    logic [7:0] txSh_ff;
    logic txPar_ff;
    logic txStop_ff;
    logic txDone;

    assign txDone = txCnt_ff == 17'h0;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            txSt_ff <= stf_pkg::U_IDLE;
            txCnt_ff <= 17'h0;
            txBit_ff <= 3'h0;
            txSh_ff <= 8'h00;
            txPar_ff <= 1'b0;
            txStop_ff <= 1'b0;
            txd <= 1'b1;
        end else begin
            txCnt_ff <= (txDone || !txBusy) ? div - 17'h1 : txCnt_ff - 17'h1;
            case (txSt_ff)
                stf_pkg::U_IDLE: begin
                    if (txPop) begin
                        txSh_ff <= bufData;
                        txPar_ff <= actCfg_ff.parity == stf_pkg::PAR_ODD;
                        txd <= 1'b0;
                        txSt_ff <= stf_pkg::U_START;
                    end
                end
                stf_pkg::U_START: begin
                    if (txDone) begin
                        txd <= txSh_ff[0];
                        txPar_ff <= txPar_ff ^ txSh_ff[0];
                        txSh_ff <= {1'b0, txSh_ff[7:1]};
                        txBit_ff <= 3'h0;
                        txSt_ff <= stf_pkg::U_DATA;
                    end
                end
                stf_pkg::U_DATA: begin
                    if (txDone) begin
                        if (txBit_ff == lastIdx) begin
                            txStop_ff <= actCfg_ff.stop2;
                            if (actCfg_ff.parity != stf_pkg::PAR_NONE) begin
                                txd <= txPar_ff;
                                txSt_ff <= stf_pkg::U_PAR;
                            end else begin
                                txd <= 1'b1;
                                txSt_ff <= stf_pkg::U_STOP;
                            end
                        end else begin
                            txd <= txSh_ff[0];
                            txPar_ff <= txPar_ff ^ txSh_ff[0];
                            txSh_ff <= {1'b0, txSh_ff[7:1]};
                            txBit_ff <= txBit_ff + 3'h1;
                        end
                    end
                end
                stf_pkg::U_PAR: begin
                    if (txDone) begin
                        txd <= 1'b1;
                        txSt_ff <= stf_pkg::U_STOP;
                    end
                end
                stf_pkg::U_STOP: begin
                    if (txDone) begin
                        if (txStop_ff) begin
                            txStop_ff <= 1'b0;
                        end else begin
                            txSt_ff <= stf_pkg::U_IDLE;
                        end
                    end
                end
                default: txSt_ff <= stf_pkg::U_IDLE;
            endcase
        end
    end

    // Serial receiver
    stf_pkg::stf_ust_t rxSt_ff;
    logic [16:0] rxCnt_ff;
    logic [2:0] rxBit_ff;
    logic [7:0] rxSh_ff;
    logic rxPar_ff;
    logic rxParBad_ff;
    logic rxValid_ff;
    logic [7:0] rxByte_ff;
    logic rxDone;

    assign rxDone = rxCnt_ff == 17'h0;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rxSt_ff <= stf_pkg::U_IDLE;
            rxCnt_ff <= 17'h0;
            rxBit_ff <= 3'h0;
            rxSh_ff <= 8'h00;
            rxPar_ff <= 1'b0;
            rxParBad_ff <= 1'b0;
            rxValid_ff <= 1'b0;
            rxByte_ff <= 8'h00;
            stickySet <= 3'h0;
        end else begin
            rxValid_ff <= 1'b0;
            stickySet <= 3'h0;
            rxCnt_ff <= rxDone ? div - 17'h1 : rxCnt_ff - 17'h1;
            case (rxSt_ff)
                stf_pkg::U_IDLE: begin
                    rxCnt_ff <= {1'b0, div[16:1]};
                    if (!rxd) begin
                        rxSt_ff <= stf_pkg::U_START;
                    end
                end
                stf_pkg::U_START: begin
                    if (rxDone) begin
                        rxSt_ff <= rxd ? stf_pkg::U_IDLE : stf_pkg::U_DATA;
                        rxBit_ff <= 3'h0;
                        rxPar_ff <= actCfg_ff.parity == stf_pkg::PAR_ODD;
                    end
                end
                stf_pkg::U_DATA: begin
                    if (rxDone) begin
                        rxSh_ff <= {rxd, rxSh_ff[7:1]};
                        rxPar_ff <= rxPar_ff ^ rxd;
                        rxBit_ff <= rxBit_ff + 3'h1;
                        rxParBad_ff <= 1'b0;
                        if (rxBit_ff == lastIdx) begin
                            rxSt_ff <= (actCfg_ff.parity != stf_pkg::PAR_NONE) ? stf_pkg::U_PAR : stf_pkg::U_STOP;
                        end
                    end
                end
                stf_pkg::U_PAR: begin
                    if (rxDone) begin
                        rxParBad_ff <= rxd != rxPar_ff;
                        rxSt_ff <= stf_pkg::U_STOP;
                    end
                end
                stf_pkg::U_STOP: begin
                    if (rxDone) begin
                        rxSt_ff <= stf_pkg::U_IDLE;
                        stickySet[stf_pkg::ST_PERR] <= rxParBad_ff;
                        stickySet[stf_pkg::ST_FERR] <= !rxd;
                        rxValid_ff <= rxd && !rxParBad_ff;
                        rxByte_ff <= rxSh_ff >> (3'h7 - lastIdx);
                    end
                end
                default: rxSt_ff <= stf_pkg::U_IDLE;
            endcase
            stickySet[stf_pkg::ST_OVR] <= rxValid_ff && netTxValid && !netTxReady;
        end
    end

    // Serial to network framing
    logic take;
    logic [10:0] byteCnt_ff;
    logic [13:0] tmoMs_ff;
    logic lenHit;
    logic tmoHit;

    assign take = rxValid_ff && !(netTxValid && !netTxReady);
    assign lenHit = take && (byteCnt_ff + 11'h1 >= actLen_ff);
    assign tmoHit = byteCnt_ff != 11'h0 && msTick_ff && (tmoMs_ff + 14'h1 >= actTmo_ff);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            netTxValid <= 1'b0;
            netTxData <= 8'h00;
        end else if (take) begin
            netTxValid <= 1'b1;
            netTxData <= rxByte_ff;
        end else if (netTxReady) begin
            netTxValid <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            byteCnt_ff <= 11'h0;
            tmoMs_ff <= 14'h0;
            frameEnd <= 1'b0;
            frameLen <= 11'h0;
        end else begin
            frameEnd <= 1'b0;
            if (lenHit) begin
                frameEnd <= 1'b1;
                frameLen <= byteCnt_ff + 11'h1;
                byteCnt_ff <= 11'h0;
                tmoMs_ff <= 14'h0;
            end else if (tmoHit) begin
                frameEnd <= 1'b1;
                frameLen <= byteCnt_ff;
                byteCnt_ff <= take ? 11'h1 : 11'h0;
                tmoMs_ff <= 14'h0;
            end else begin
                if (take) begin
                    byteCnt_ff <= byteCnt_ff + 11'h1;
                end
                if (byteCnt_ff == 11'h0) begin
                    tmoMs_ff <= 14'h0;
                end else if (msTick_ff) begin
                    tmoMs_ff <= tmoMs_ff + 14'h1;
                end
            end
        end
    end

    // Link supervision
    logic [15:0] idleSec_ff;
    logic [15:0] retrySec_ff;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            idleSec_ff <= 16'h0;
            linkDrop <= 1'b0;
        end else begin
            linkDrop <= 1'b0;
            if (!actCfg_ff.server || actCfg_ff.udp || !netConnected || netPktRx) begin
                idleSec_ff <= 16'h0;
            end else if (secTick_ff) begin
                if ({1'b0, idleSec_ff} + 17'h1 >= {1'b0, actLink_ff}) begin
                    linkDrop <= 1'b1;
                    idleSec_ff <= 16'h0;
                end else begin
                    idleSec_ff <= idleSec_ff + 16'h1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            retrySec_ff <= 16'h0;
            reconnectReq <= 1'b0;
        end else begin
            reconnectReq <= 1'b0;
            if (actCfg_ff.server || actCfg_ff.udp || netConnected) begin
                retrySec_ff <= 16'h0;
            end else if (secTick_ff) begin
                if ({1'b0, retrySec_ff} + 17'h1 >= {1'b0, actRetry_ff}) begin
                    reconnectReq <= 1'b1;
                    retrySec_ff <= 16'h0;
                end else begin
                    retrySec_ff <= retrySec_ff + 16'h1;
                end
            end
        end
    end
endmodule // stf_packetizer

//--- stf_packetizer_chk.sv
`timescale 1ns/1ps
module stf_packetizer_chk (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic frameEnd,
    input wire logic [10:0] frameLen,
    input wire logic netPktRx,
    input wire logic netConnected,
    input wire logic linkDrop,
    input wire logic reconnectReq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    frame_pulse_a: assert property (frameEnd |=> !frameEnd) else $error("frame end too long");
    frame_len_a: assert property (frameEnd |-> frameLen != 11'h000 && frameLen <= 11'h400)
        else $error("bad frame length");
    len_hold_a: assert property (!frameEnd |-> $stable(frameLen)) else $error("frame length moved");
    drop_conn_a: assert property (linkDrop |-> $past(netConnected)) else $error("drop while down");
    drop_pkt_a: assert property (netPktRx |-> ##2 !linkDrop [*8]) else $error("drop after packet");
    retry_gap_a: assert property (reconnectReq |=> !reconnectReq [*8]) else $error("retry too soon");
    retry_down_a: assert property (reconnectReq |-> !$past(netConnected)) else $error("retry while up");
    link_excl_a: assert property (!(linkDrop && reconnectReq)) else $error("drop and retry together");
    frame_cov: cover property (frameEnd);
    short_cov: cover property (frameEnd && frameLen == 11'h001);
    retry_cov: cover property (reconnectReq);
endmodule // stf_packetizer_chk

bind stf_packetizer stf_packetizer_chk stf_packetizer_chk_inst (.clk, .sys_rst, .frameEnd, .frameLen, .netPktRx,
    .netConnected, .linkDrop, .reconnectReq);

//--- stf_field_dev.sv
`timescale 1ns/1ps
module stf_field_dev #(
    parameter int DIV = 868
) (
    input wire logic clk,
    input wire logic txd,
    output logic rxd,
    output logic cts
);
    logic [7:0] got[$];
    logic [7:0] sh;
    initial rxd = 1'b1;
    initial cts = 1'b0;
    // Start, eight data bits LSB first, one stop
    task automatic send(input logic [7:0] b);
        for (int i = 0; i < 10; i++) begin
            rxd <= i == 0 ? 1'b0 : i == 9 ? 1'b1 : b[3'(i - 1)];
            repeat (DIV) @(posedge clk);
        end
    endtask
    always begin
        @(negedge txd);
        repeat (DIV / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (DIV) @(posedge clk);
            sh[i] = txd;
        end
        got.push_back(sh);
        repeat (DIV) @(posedge clk);
    end
endmodule // stf_field_dev

//--- serial_to_frame_packetizer_bench.sv
`timescale 1ns/1ps
module serial_to_frame_packetizer_bench;
    logic clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, netRxValid = 1'b0, netPktRx = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic [1:0] htrans = 2'h0;
    logic [7:0] netRxData = 8'h0, netTxData, b;
    logic hready, hreadyout, hresp, rxd, txd, cts, rts, netRxReady, netTxValid, frameEnd, linkDrop, reconnectReq;
    logic [10:0] frameLen;
    logic netConnected = 1'b0;
    logic [7:0] fromNet[$], expQ[$];
    int bad_count = 0, n_compared = 0, n;
    time tByte;
    assign hready = hreadyout;
    always #5 clk = ~clk;
    stf_packetizer #(.CYC_PER_MS(20), .CYC_PER_SEC(200)) stf_packetizer_inst (.clk, .sys_rst, .hsel, .haddr,
        .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout, .hresp, .rxd, .txd, .cts, .rts,
        .netRxValid, .netRxData, .netRxReady, .netTxValid, .netTxData, .netTxReady(1'b1), .frameEnd, .frameLen,
        .netPktRx, .netConnected, .linkDrop, .reconnectReq);
    stf_field_dev stf_field_dev_inst (.clk, .txd, .rxd, .cts);
    always @(posedge clk) if (netTxValid) begin
        fromNet.push_back(netTxData);
        tByte = $time;
    end
    task automatic report_and_stop;
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        n_compared++;
        if (got !== want) begin
            bad_count++;
            $display("Error at %0t: saw %h, expected %h", $time, got, want);
        end
    endtask
    task automatic over(input int lim);
        if (n >= lim) begin
            bad_count++;
            $display("Error at %0t: wait ran out", $time);
            report_and_stop();
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        @(posedge clk);
        for (n = 0; hready !== 1'b1 && n < 50; n++) @(posedge clk);
        over(50);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge clk);
        for (n = 0; hready !== 1'b1 && n < 50; n++) @(posedge clk);
        over(50);
        r = hrdata;
        if (!wr) chk(r, d);
    endtask
    initial begin
        void'($urandom(32'h0A55));
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        bus(1'b0, stf_pkg::ADDR_TRIG_LEN, 32'h40);
        bus(1'b0, stf_pkg::ADDR_TRIG_TMO, 32'h50);
        bus(1'b0, stf_pkg::ADDR_ACTIVE, 32'h1F);
        bus(1'b0, 8'h40, 32'h0);
        $display("Test defaults done");
        for (n = 0; reconnectReq !== 1'b1 && n < 2100; n++) @(posedge clk);
        over(2100);
        @(posedge clk);
        for (n = 1; reconnectReq !== 1'b1 && n < 2100; n++) @(posedge clk);
        chk(n, 32'h7D0);
        $display("Test retry done");
        bus(1'b1, stf_pkg::ADDR_TRIG_LEN, 32'h5);
        bus(1'b0, stf_pkg::ADDR_TRIG_LEN, 32'h20);
        bus(1'b1, stf_pkg::ADDR_TRIG_TMO, 32'h1);
        bus(1'b0, stf_pkg::ADDR_TRIG_TMO, 32'h32);
        bus(1'b1, stf_pkg::ADDR_LINK_TMO, 32'h2);
        bus(1'b1, stf_pkg::ADDR_CFG, 32'h41F);
        bus(1'b0, stf_pkg::ADDR_STATUS, 32'h8);
        repeat (2100) @(posedge clk);
        bus(1'b0, stf_pkg::ADDR_STATUS, 32'h0);
        $display("Test settings done");
        netConnected <= 1'b1;
        for (n = 0; linkDrop !== 1'b1 && n < 500; n++) @(posedge clk);
        over(500);
        @(posedge clk);
        for (n = 1; linkDrop !== 1'b1 && n < 500; n++) @(posedge clk);
        chk(n, 32'h190);
        $display("Test link done");
        repeat (2) begin
            b = 8'($urandom);
            netPktRx <= 1'b1;
            stf_field_dev_inst.send(b);
            netPktRx <= 1'b0;
            for (n = 0; frameEnd !== 1'b1 && n < 3000; n++) @(posedge clk);
            over(3000);
            chk(frameLen, 32'h1);
            chk(fromNet.pop_front(), b);
            n = int'(($time - tByte) / 10);
            chk(n >= 980 && n <= 1030, 32'h1);
        end
        $display("Test framing done");
        repeat (3) begin
            b = 8'($urandom);
            expQ.push_back(b);
            netRxValid <= 1'b1;
            netRxData <= b;
            @(posedge clk);
            for (n = 0; netRxReady !== 1'b1 && n < 30000; n++) @(posedge clk);
            over(30000);
        end
        netRxValid <= 1'b0;
        chk(rts, 32'h0);
        for (n = 0; stf_field_dev_inst.got.size() < 3 && n < 40000; n++) @(posedge clk);
        over(40000);
        foreach (expQ[i]) chk(stf_field_dev_inst.got[i], expQ[i]);
        $display("Test network to serial done");
        report_and_stop();
    end
endmodule // serial_to_frame_packetizer_bench
